/* File: logic/iep_irq_enable_priority.sv */
// Interrupt enable and priority registers with request gating toward the core
`timescale 1ns/1ps
`default_nettype none
module iep_irq_enable_priority (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_bit_wr_in,
  input wire logic [2:0] sfr_bit_sel_in,
  input wire logic sfr_bit_val_in,
  input wire logic sfr_rd_in,
  input wire logic ext_irq0_pending_in,
  input wire logic timer0_overflow_flag_in,
  input wire logic ext_irq1_pending_in,
  input wire logic timer1_overflow_flag_in,
  input wire logic uart_port_pending_in,
  input wire logic timer2_low_overflow_flag_in,
  input wire logic timer2_high_overflow_flag_in,
  input wire logic spi_port_pending_in,
  input wire logic smbus_port0_pending_in,
  input wire logic port_match_pending_in,
  input wire logic window_compare_flag_in,
  input wire logic conversion_done_flag_in,
  input wire logic counter_array_pending_in,
  input wire logic comparator_rising_flag_in,
  input wire logic comparator_falling_flag_in,
  input wire logic timer3_low_overflow_flag_in,
  input wire logic timer3_high_overflow_flag_in,
  output logic irq_req_out,
  output logic [1:0] irq_level_out,
  output logic [3:0] irq_source_out,
  output logic [14:0] irq_active_out,
  output logic [7:0] sfr_rd_data_out,
  output logic sfr_rd_hit_out
);
  iep_pkg::iep_top_st_t st_q;
  iep_pkg::iep_top_st_t st_d;

  logic [7:0] enable_val;
  logic [7:0] prio_low_val;
  logic [7:0] prio_high_val;
  logic [7:0] enable_ext1_val;
  logic bit_ok;
  logic wr_enable;
  logic wr_prio_low;
  logic wr_prio_high;
  logic wr_enable_ext1;
  logic bwr_enable;
  logic bwr_prio_low;
  logic bwr_prio_high;
  logic [14:0] raw_req;
  logic [14:0] src_en;
  logic [14:0] masked_req;
  logic [29:0] src_level;
  logic arb_any;
  logic [1:0] arb_level;
  logic [3:0] arb_source;

  // Register decode ignores the page select: all four live on every page
  assign bit_ok = iep_pkg::iep_bit_addressable(sfr_addr_in);
  assign wr_enable = sfr_wr_in && (sfr_addr_in == iep_pkg::IEP_ADDR_ENABLE);
  assign wr_prio_low = sfr_wr_in && (sfr_addr_in == iep_pkg::IEP_ADDR_PRIO_LOW);
  assign wr_prio_high = sfr_wr_in && (sfr_addr_in == iep_pkg::IEP_ADDR_PRIO_HIGH);
  assign wr_enable_ext1 = sfr_wr_in && (sfr_addr_in == iep_pkg::IEP_ADDR_ENABLE_EXT1);
  // A byte write in the same cycle takes precedence over a bit write
  assign bwr_enable = sfr_bit_wr_in && bit_ok && (sfr_addr_in == iep_pkg::IEP_ADDR_ENABLE);
  assign bwr_prio_low = sfr_bit_wr_in && bit_ok && (sfr_addr_in == iep_pkg::IEP_ADDR_PRIO_LOW);
  assign bwr_prio_high = sfr_bit_wr_in && bit_ok && (sfr_addr_in == iep_pkg::IEP_ADDR_PRIO_HIGH);

  iep_sfr_byte #(
    .RESET_VAL(iep_pkg::IEP_RST_ENABLE),
    .FIXED_ONES(iep_pkg::IEP_FIXED_NONE)
  ) u_enable (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .wr_in(wr_enable),
    .wdata_in(sfr_wdata_in),
    .bit_wr_in(bwr_enable),
    .bit_sel_in(sfr_bit_sel_in),
    .bit_val_in(sfr_bit_val_in),
    .value_out(enable_val)
  );

  iep_sfr_byte #(
    .RESET_VAL(iep_pkg::IEP_RST_PRIO),
    .FIXED_ONES(iep_pkg::IEP_FIXED_PRIO)
  ) u_prio_low (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .wr_in(wr_prio_low),
    .wdata_in(sfr_wdata_in),
    .bit_wr_in(bwr_prio_low),
    .bit_sel_in(sfr_bit_sel_in),
    .bit_val_in(sfr_bit_val_in),
    .value_out(prio_low_val)
  );

  iep_sfr_byte #(
    .RESET_VAL(iep_pkg::IEP_RST_PRIO),
    .FIXED_ONES(iep_pkg::IEP_FIXED_PRIO)
  ) u_prio_high (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .wr_in(wr_prio_high),
    .wdata_in(sfr_wdata_in),
    .bit_wr_in(bwr_prio_high),
    .bit_sel_in(sfr_bit_sel_in),
    .bit_val_in(sfr_bit_val_in),
    .value_out(prio_high_val)
  );

  // Not bit-addressable, so only byte writes reach it
  iep_sfr_byte #(
    .RESET_VAL(iep_pkg::IEP_RST_ENABLE),
    .FIXED_ONES(iep_pkg::IEP_FIXED_NONE)
  ) u_enable_ext1 (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .wr_in(wr_enable_ext1),
    .wdata_in(sfr_wdata_in),
    .bit_wr_in(1'b0),
    .bit_sel_in(sfr_bit_sel_in),
    .bit_val_in(sfr_bit_val_in),
    .value_out(enable_ext1_val)
  );

  // Request sources in vector order; the basic ones share their bit index
  always_comb begin
    raw_req = '0;
    src_en = '0;
    raw_req[iep_pkg::IEP_SRC_EXT0] = ext_irq0_pending_in;
    src_en[iep_pkg::IEP_SRC_EXT0] = enable_val[iep_pkg::IEP_SRC_EXT0];
    raw_req[iep_pkg::IEP_SRC_TIMER0] = timer0_overflow_flag_in;
    src_en[iep_pkg::IEP_SRC_TIMER0] = enable_val[iep_pkg::IEP_SRC_TIMER0];
    raw_req[iep_pkg::IEP_SRC_EXT1] = ext_irq1_pending_in;
    src_en[iep_pkg::IEP_SRC_EXT1] = enable_val[iep_pkg::IEP_SRC_EXT1];
    raw_req[iep_pkg::IEP_SRC_TIMER1] = timer1_overflow_flag_in;
    src_en[iep_pkg::IEP_SRC_TIMER1] = enable_val[iep_pkg::IEP_SRC_TIMER1];
    raw_req[iep_pkg::IEP_SRC_UART] = uart_port_pending_in;
    src_en[iep_pkg::IEP_SRC_UART] = enable_val[iep_pkg::IEP_SRC_UART];
    raw_req[iep_pkg::IEP_SRC_TIMER2] = timer2_low_overflow_flag_in ||
                                       timer2_high_overflow_flag_in;
    src_en[iep_pkg::IEP_SRC_TIMER2] = enable_val[iep_pkg::IEP_SRC_TIMER2];
    raw_req[iep_pkg::IEP_SRC_SPI] = spi_port_pending_in;
    src_en[iep_pkg::IEP_SRC_SPI] = enable_val[iep_pkg::IEP_SRC_SPI];
    raw_req[iep_pkg::IEP_SRC_SMBUS0] = smbus_port0_pending_in;
    src_en[iep_pkg::IEP_SRC_SMBUS0] = enable_ext1_val[iep_pkg::IEP_BIT_SMBUS0];
    raw_req[iep_pkg::IEP_SRC_PORT_MATCH] = port_match_pending_in;
    src_en[iep_pkg::IEP_SRC_PORT_MATCH] = enable_ext1_val[iep_pkg::IEP_BIT_PORT_MATCH];
    raw_req[iep_pkg::IEP_SRC_WINDOW] = window_compare_flag_in;
    src_en[iep_pkg::IEP_SRC_WINDOW] = enable_ext1_val[iep_pkg::IEP_BIT_WINDOW];
    raw_req[iep_pkg::IEP_SRC_CONV_DONE] = conversion_done_flag_in;
    src_en[iep_pkg::IEP_SRC_CONV_DONE] = enable_ext1_val[iep_pkg::IEP_BIT_CONV_DONE];
    raw_req[iep_pkg::IEP_SRC_COUNTER_ARRAY] = counter_array_pending_in;
    src_en[iep_pkg::IEP_SRC_COUNTER_ARRAY] =
      enable_ext1_val[iep_pkg::IEP_BIT_COUNTER_ARRAY];
    raw_req[iep_pkg::IEP_SRC_COMPARATOR] = comparator_rising_flag_in ||
                                           comparator_falling_flag_in;
    src_en[iep_pkg::IEP_SRC_COMPARATOR] = enable_ext1_val[iep_pkg::IEP_BIT_COMPARATOR];
    // Vector slot 13 has no source; extended bit 6 steers nothing
    raw_req[iep_pkg::IEP_SRC_TIMER3] = timer3_low_overflow_flag_in ||
                                       timer3_high_overflow_flag_in;
    src_en[iep_pkg::IEP_SRC_TIMER3] = enable_ext1_val[iep_pkg::IEP_BIT_TIMER3];
  end

  // Global enable gates every source after its own mask
  assign masked_req = raw_req & src_en & {15{enable_val[iep_pkg::IEP_BIT_GLOBAL]}};

  // Extended sources sit at level 0 until their priority registers exist
  always_comb begin
    src_level = '0;
    for (int i = 0; i < iep_pkg::IEP_NUM_BASIC; i++) begin
      src_level[2*i +: 2] = iep_pkg::iep_level(prio_high_val[i], prio_low_val[i]);
    end
  end

  iep_prio_arb u_arb (
    .active_in(masked_req),
    .level_in(src_level),
    .any_out(arb_any),
    .level_out(arb_level),
    .source_out(arb_source)
  );

  always_comb begin
    st_d = st_q;
    st_d.req = arb_any;
    st_d.level = arb_level;
    st_d.source = arb_source;
    st_d.active = masked_req;
    st_d.rd_hit = 1'b0;
    st_d.rd_data = '0;
    if (sfr_rd_in) begin
      st_d.rd_hit = 1'b1;
      case (sfr_addr_in)
        iep_pkg::IEP_ADDR_ENABLE: begin
          st_d.rd_data = enable_val;
        end
        iep_pkg::IEP_ADDR_PRIO_LOW: begin
          st_d.rd_data = prio_low_val;
        end
        iep_pkg::IEP_ADDR_PRIO_HIGH: begin
          st_d.rd_data = prio_high_val;
        end
        iep_pkg::IEP_ADDR_ENABLE_EXT1: begin
          st_d.rd_data = enable_ext1_val;
        end
        default: begin
          st_d.rd_hit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_q <= iep_pkg::IEP_TOP_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign irq_req_out = st_q.req;
  assign irq_level_out = st_q.level;
  assign irq_source_out = st_q.source;
  assign irq_active_out = st_q.active;
  assign sfr_rd_data_out = st_q.rd_data;
  assign sfr_rd_hit_out = st_q.rd_hit;

  // Checks on the gating, the decode and the register file
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  a_global_off: assert property (
    !enable_val[7] |=> !irq_req_out && (irq_active_out == '0))
    else $error("Request seen with global enable clear");

  a_global_on_pass: assert property (
    enable_val[7] && enable_val[0] && ext_irq0_pending_in |=> irq_req_out)
    else $error("Enabled external 0 did not raise a request");

  a_spi_mask: assert property (
    (enable_val[7:6] == 2'h3) && spi_port_pending_in |=> irq_active_out[6])
    else $error("Enabled SPI request not active");

  a_timer2_either: assert property (
    enable_val[7] && enable_val[5] && timer2_high_overflow_flag_in
    |=> irq_active_out[5])
    else $error("Timer 2 high flag alone did not request");

  a_basic_masks: assert property (
    $past(!enable_val[4] && !enable_val[3] && !enable_val[2] && !enable_val[1])
    |-> (irq_active_out[4:1] == 4'h0))
    else $error("Masked basic source still active");

  a_basic_pass: assert property (
    enable_val[7] && enable_val[3] && timer1_overflow_flag_in |=> irq_active_out[3])
    else $error("Enabled timer 1 request not active");

  a_ext1_pass: assert property (
    enable_val[7] && enable_val[2] && ext_irq1_pending_in |=> irq_active_out[2])
    else $error("Enabled external 1 request not active");

  a_timer0_pass: assert property (
    enable_val[7] && enable_val[1] && timer0_overflow_flag_in |=> irq_active_out[1])
    else $error("Enabled timer 0 request not active");

  a_ext0_mask: assert property (
    !enable_val[0] |=> !irq_active_out[0])
    else $error("Masked external 0 still active");

  logic enable_val_ext1_ok;
  assign enable_val_ext1_ok = (enable_ext1_val == 8'h00);

  a_reset_values: assert property (
    disable iff (1'b0) rst_in |=> (enable_val == 8'h00) && (enable_val_ext1_ok) &&
    (prio_low_val == 8'h80) && (prio_high_val == 8'h80))
    else $error("Register reset value wrong");

  a_enable_bitwr: assert property (
    sfr_bit_wr_in && !sfr_wr_in && (sfr_addr_in == 8'hA8)
    |=> enable_val[$past(sfr_bit_sel_in)] == $past(sfr_bit_val_in))
    else $error("Bit write to enable register lost");

  a_unused_one: assert property (
    ##1 (prio_low_val[7] && prio_high_val[7]))
    else $error("Unused priority bit read as zero");

  a_prio_readback: assert property (
    sfr_rd_in && (sfr_addr_in == 8'h84) |=> sfr_rd_hit_out && sfr_rd_data_out[7])
    else $error("High priority readback wrong");

  a_level_decode: assert property (
    enable_val[7] && enable_val[6] && spi_port_pending_in && (masked_req == 15'h0040)
    |=> irq_level_out == {$past(prio_high_val[6]), $past(prio_low_val[6])})
    else $error("SPI level decode wrong");

  a_prio_high_bitwr: assert property (
    sfr_bit_wr_in && !sfr_wr_in && (sfr_addr_in == 8'h84) && (sfr_bit_sel_in == 3'h7)
    |=> prio_high_val[7])
    else $error("Bit write cleared unused priority bit");

  a_ext1_bytewr: assert property (
    sfr_wr_in && (sfr_addr_in == 8'hE6) |=> enable_ext1_val == $past(sfr_wdata_in))
    else $error("Extended enable write lost");

  a_ext1_no_bitwr: assert property (
    sfr_bit_wr_in && !sfr_wr_in && (sfr_addr_in == 8'hE6)
    |=> $stable(enable_ext1_val))
    else $error("Extended enable took a bit write");

  a_timer3_either: assert property (
    enable_val[7] && enable_ext1_val[7] && timer3_low_overflow_flag_in |=> irq_active_out[14])
    else $error("Timer 3 low flag alone did not request");

  a_comparator_edge: assert property (
    enable_val[7] && enable_ext1_val[5] && comparator_falling_flag_in |=> irq_active_out[12])
    else $error("Comparator falling flag did not request");

  a_ext_masks: assert property (
    (enable_ext1_val[4:0] == 5'h00) |=> (irq_active_out[11:7] == 5'h00))
    else $error("Masked extended source still active");

  a_ext_pass: assert property (
    enable_val[7] && enable_ext1_val[0] && smbus_port0_pending_in |=> irq_active_out[7])
    else $error("Enabled SMBus 0 request not active");

  a_top_level_wins: assert property (
    enable_val[7] && enable_val[0] && ext_irq0_pending_in && prio_high_val[0] &&
    prio_low_val[0] |=> irq_req_out && (irq_level_out == 2'h3))
    else $error("Level 3 source not granted level 3");

  // Timer 0 must never beat external 0 at an equal level, whatever else is pending
  a_tie_lowest: assert property (
    (masked_req[1:0] == 2'h3) && (src_level[1:0] == src_level[3:2])
    |=> irq_req_out && (irq_source_out != 4'h1))
    else $error("Tie not resolved to lowest order");

  c_level_three: cover property (irq_req_out && (irq_level_out == 2'h3));
  c_extended_grant: cover property (irq_req_out && (irq_source_out == 4'hE));
  c_bit_write: cover property (sfr_bit_wr_in && bit_ok ##1 sfr_rd_in ##1 sfr_rd_hit_out);
  c_global_drop: cover property (irq_req_out ##1 !enable_val[7] ##1 !irq_req_out);
endmodule
`default_nettype wire

/* File: logic/iep_pkg.sv */
// Constants, types and helpers for the interrupt enable and priority registers
// Functional notes
// - Global enable overrides every individual mask
// - Enable bit 6 masks the SPI port
// - Enable bit 5 masks timer 2 overflows
// - Enable bit 4 masks the UART port
// - Enable bit 3 masks timer 1 overflow
// - Enable bit 2 masks external interrupt 1
// - Enable bit 1 masks timer 0 overflow
// - Enable bit 0 masks external interrupt 0
// - Basic enable: all pages, bit-addressable, resets zero
// - Priority bit 7 reads one, ignores writes
// - Low priority bits 6..0 give level LSBs
// - High priority bits 6..0 give level MSBs
// - Priority registers: all pages, bit-addressable, reset 0x80
// - Extended bit 7 masks timer 3 overflows
// - Extended bit 5 masks comparator edge flags
// - Extended bit 4 masks the counter array
// - Extended bit 3 masks conversion done
// - Extended bit 2 masks window compare
// - Extended bit 1 masks port match events
// - Extended bit 0 masks SMBus port 0
// - Extended enable: all pages, read/write, resets zero
// - Level 3 highest, level 0 lowest default
// - Equal levels resolved by lowest vector order
`default_nettype none
package iep_pkg;
  localparam logic [7:0] IEP_ADDR_PRIO_HIGH = 8'h84;
  localparam logic [7:0] IEP_ADDR_ENABLE = 8'hA8;
  localparam logic [7:0] IEP_ADDR_PRIO_LOW = 8'hB8;
  localparam logic [7:0] IEP_ADDR_ENABLE_EXT1 = 8'hE6;
  localparam logic [7:0] IEP_RST_ENABLE = 8'h00;
  localparam logic [7:0] IEP_RST_PRIO = 8'h80;
  localparam logic [7:0] IEP_FIXED_NONE = 8'h00;
  localparam logic [7:0] IEP_FIXED_PRIO = 8'h80;
  localparam int IEP_BIT_GLOBAL = 7;
  localparam int IEP_BIT_UNUSED = 7;
  localparam int IEP_BIT_TIMER3 = 7;
  localparam int IEP_BIT_COMPARATOR = 5;
  localparam int IEP_BIT_COUNTER_ARRAY = 4;
  localparam int IEP_BIT_CONV_DONE = 3;
  localparam int IEP_BIT_WINDOW = 2;
  localparam int IEP_BIT_PORT_MATCH = 1;
  localparam int IEP_BIT_SMBUS0 = 0;
  localparam int IEP_SRC_EXT0 = 0;
  localparam int IEP_SRC_TIMER0 = 1;
  localparam int IEP_SRC_EXT1 = 2;
  localparam int IEP_SRC_TIMER1 = 3;
  localparam int IEP_SRC_UART = 4;
  localparam int IEP_SRC_TIMER2 = 5;
  localparam int IEP_SRC_SPI = 6;
  localparam int IEP_SRC_SMBUS0 = 7;
  localparam int IEP_SRC_PORT_MATCH = 8;
  localparam int IEP_SRC_WINDOW = 9;
  localparam int IEP_SRC_CONV_DONE = 10;
  localparam int IEP_SRC_COUNTER_ARRAY = 11;
  localparam int IEP_SRC_COMPARATOR = 12;
  localparam int IEP_SRC_RESERVED = 13;
  localparam int IEP_SRC_TIMER3 = 14;
  localparam int IEP_NUM_SRC = 15;
  localparam int IEP_NUM_BASIC = 7;
  localparam int IEP_SRC_W = 4;
  localparam int IEP_LVL_W = 2;
  localparam logic [1:0] IEP_LVL_MIN = 2'h0;
  localparam logic [1:0] IEP_LVL_MAX = 2'h3;

  typedef struct packed {
    logic [7:0] val;
  } iep_byte_st_t;

  typedef struct packed {
    logic req;
    logic [IEP_LVL_W-1:0] level;
    logic [IEP_SRC_W-1:0] source;
    logic [IEP_NUM_SRC-1:0] active;
    logic [7:0] rd_data;
    logic rd_hit;
  } iep_top_st_t;

  localparam iep_top_st_t IEP_TOP_RST = '0;

  // Level is MSB from the high register over LSB from the low register
  function automatic logic [IEP_LVL_W-1:0] iep_level(input logic hi, input logic lo);
    iep_level = {hi, lo};
  endfunction

  // Only the enable and both priority registers take single-bit writes
  function automatic logic iep_bit_addressable(input logic [7:0] addr);
    iep_bit_addressable = (addr == IEP_ADDR_ENABLE) || (addr == IEP_ADDR_PRIO_LOW) ||
                          (addr == IEP_ADDR_PRIO_HIGH);
  endfunction
endpackage
`default_nettype wire

/* File: logic/iep_prio_arb.sv */
// Picks the highest-level active source, lowest vector order on a tie
`timescale 1ns/1ps
`default_nettype none
module iep_prio_arb (
  input wire logic [14:0] active_in,
  input wire logic [29:0] level_in,
  output logic any_out,
  output logic [1:0] level_out,
  output logic [3:0] source_out
);
  always_comb begin
    any_out = 1'b0;
    level_out = iep_pkg::IEP_LVL_MIN;
    source_out = '0;
    for (int i = 0; i < iep_pkg::IEP_NUM_SRC; i++) begin
      // Strict compare keeps the earlier source when levels match
      if (active_in[i] && (!any_out || (level_in[2*i +: 2] > level_out))) begin
        any_out = 1'b1;
        level_out = level_in[2*i +: 2];
        source_out = 4'(i);
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/iep_sfr_byte.sv */
// One eight-bit special-function register with byte and single-bit writes
`timescale 1ns/1ps
`default_nettype none
module iep_sfr_byte #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] FIXED_ONES = 8'h00
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic bit_wr_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic bit_val_in,
  output logic [7:0] value_out
);
  iep_pkg::iep_byte_st_t st_q;
  iep_pkg::iep_byte_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (wr_in) begin
      st_d.val = wdata_in;
    end else if (bit_wr_in) begin
      st_d.val[bit_sel_in] = bit_val_in;
    end
    // Fixed bits stay one whatever software writes
    st_d.val = st_d.val | FIXED_ONES;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_q.val <= RESET_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  assign value_out = st_q.val;
endmodule
`default_nettype wire

/* File: verification/iep_core_model.sv */
// Core-side model that issues register reads and writes toward the block
`timescale 1ns/1ps
`default_nettype none
module iep_core_model (
  input wire logic clk_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_hit_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic [7:0] wdata_out,
  output logic bit_wr_out,
  output logic [2:0] bit_sel_out,
  output logic bit_val_out,
  output logic rd_out
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    bit_wr_out = 1'b0;
    bit_sel_out = 3'h0;
    bit_val_out = 1'b0;
    rd_out = 1'b0;
  end

  // Strobes are single pulses; each task lets one edge pass before the next request
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= (a == 8'hE6) ? (d & 8'hBF) : d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask

  task automatic wr_bit(input logic [7:0] a, input logic [2:0] b, input logic v);
    @(posedge clk_in);
    addr_out <= a;
    bit_sel_out <= b;
    bit_val_out <= v;
    bit_wr_out <= 1'b1;
    @(posedge clk_in);
    bit_wr_out <= 1'b0;
  endtask

  // Read data stands for one cycle only, so it is taken just after the answering edge
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    d = rd_data_in;
    h = rd_hit_in;
  endtask
endmodule
`default_nettype wire

/* File: verification/iep_irq_enable_priority_test.sv */
// Self-checking bench for the interrupt enable and priority registers
`timescale 1ns/1ps
`default_nettype none
module iep_irq_enable_priority_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [16:0] flg = 17'h0_0000;
  logic [7:0] addr, wdata, rd_data;
  logic wr, bit_wr, bit_val, rd, req, hit;
  logic [2:0] bit_sel;
  logic [1:0] lvl;
  logic [3:0] src;
  logic [14:0] act;
  logic [7:0] regs [4] = '{8'h84, 8'hA8, 8'hB8, 8'hE6};
  int n_mismatch = 0;
  int samples_checked = 0;
  int m_ie = 0, m_eie = 0, m_ipl = 8'h80, m_iph = 8'h80;

  always #20 clk = ~clk;

  iep_core_model u_core (.clk_in(clk), .rd_data_in(rd_data), .rd_hit_in(hit),
    .addr_out(addr), .wr_out(wr), .wdata_out(wdata), .bit_wr_out(bit_wr),
    .bit_sel_out(bit_sel), .bit_val_out(bit_val), .rd_out(rd));

  iep_irq_enable_priority u_dut (.sys_clk_in(clk), .rst_in(rst), .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_bit_wr_in(bit_wr),
    .sfr_bit_sel_in(bit_sel), .sfr_bit_val_in(bit_val), .sfr_rd_in(rd),
    .ext_irq0_pending_in(flg[0]), .timer0_overflow_flag_in(flg[1]),
    .ext_irq1_pending_in(flg[2]), .timer1_overflow_flag_in(flg[3]),
    .uart_port_pending_in(flg[4]), .timer2_low_overflow_flag_in(flg[5]),
    .timer2_high_overflow_flag_in(flg[6]), .spi_port_pending_in(flg[7]),
    .smbus_port0_pending_in(flg[8]), .port_match_pending_in(flg[9]),
    .window_compare_flag_in(flg[10]), .conversion_done_flag_in(flg[11]),
    .counter_array_pending_in(flg[12]), .comparator_rising_flag_in(flg[13]),
    .comparator_falling_flag_in(flg[14]), .timer3_low_overflow_flag_in(flg[15]),
    .timer3_high_overflow_flag_in(flg[16]), .irq_req_out(req), .irq_level_out(lvl),
    .irq_source_out(src), .irq_active_out(act), .sfr_rd_data_out(rd_data),
    .sfr_rd_hit_out(hit));

  task automatic tally_and_finish();
    $display("Compared %0d, mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_irq(input logic [21:0] got, input logic [21:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Reference gating and arbitration; strict compare keeps the lowest order on a tie
  task automatic settle();
    logic [14:0] p;
    logic [14:0] a;
    int lv;
    int best;
    int l;
    repeat (2) @(posedge clk);
    #1;
    p = {flg[16] | flg[15], 1'b0, flg[14] | flg[13], flg[12:8], flg[7], flg[6] | flg[5],
         flg[4:0]};
    a = m_ie[7] ? (p & {m_eie[7], 1'b0, m_eie[5:0], m_ie[6:0]}) : 15'h0000;
    lv = -1;
    best = 0;
    for (int s = 0; s < 15; s++) begin
      l = (s < 7) ? {m_iph[s], m_ipl[s]} : 0;
      if (a[s] && l > lv) begin
        lv = l;
        best = s;
      end
    end
    chk_irq({req, req ? {lvl, src} : 6'h00, act},
            {|a, (|a) ? {2'(lv), 4'(best)} : 6'h00, a});
  endtask

  task automatic read_reg(input logic [7:0] a, input int e, input logic h);
    logic [7:0] d;
    logic ht;
    u_core.rd_byte(a, d, ht);
    chk_rd({ht, d}, {h, 8'(e)});
  endtask

  task automatic read_all();
    read_reg(8'hA8, m_ie, 1'b1);
    read_reg(8'hE6, m_eie, 1'b1);
    read_reg(8'hB8, m_ipl, 1'b1);
    read_reg(8'h84, m_iph, 1'b1);
    read_reg(8'h3C, 0, 1'b0);
  endtask

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    u_core.wr_byte(a, d);
    case (a)
      8'hA8: m_ie = d;
      8'hE6: m_eie = d & 8'hBF;
      8'hB8: m_ipl = d | 8'h80;
      8'h84: m_iph = d | 8'h80;
      default: ;
    endcase
  endtask

  // Single-bit writes reach only the bit-addressable registers
  task automatic put_bit(input logic [7:0] a, input logic [2:0] b, input logic v);
    u_core.wr_bit(a, b, v);
    case (a)
      8'hA8: m_ie[b] = v;
      8'hB8: if (b != 3'h7) m_ipl[b] = v;
      8'h84: if (b != 3'h7) m_iph[b] = v;
      default: ;
    endcase
  endtask

  initial begin
    #(40 * 40000);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h2ac1_7e96));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    read_all();
    put(8'hE6, 8'hFF);
    put(8'hA8, 8'h7F);
    @(posedge clk);
    flg <= 17'h1_FFFF;
    settle();
    put(8'hA8, 8'hFF);
    for (int i = 0; i < 17; i++) begin
      @(posedge clk);
      flg <= 17'h0_0001 << i;
      settle();
    end
    put(8'hB8, 8'h00);
    put_bit(8'h84, 3'h7, 1'b0);
    put_bit(8'hE6, 3'h0, 1'b0);
    put(8'h3C, 8'hFF);
    read_all();
    for (int n = 0; n < 150; n++) begin
      for (int r = 0; r < 4; r++) begin
        put(regs[$urandom_range(3, 0)], 8'($urandom));
      end
      put_bit(regs[$urandom_range(3, 0)], 3'($urandom), 1'($urandom));
      @(posedge clk);
      flg <= 17'($urandom & $urandom);
      settle();
      if (n % 8 == 0) read_all();
    end
    // Second reset after random writes must bring every register back
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    m_ie = 0;
    m_eie = 0;
    m_ipl = 8'h80;
    m_iph = 8'h80;
    read_all();
    @(posedge clk);
    flg <= 17'h1_FFFF;
    settle();
    tally_and_finish();
  end
endmodule
`default_nettype wire
